// >>> dtcd_defines.vh
`ifndef DTCD_DEFINES_VH
`define DTCD_DEFINES_VH
// Clock rate of clk_sys in MHz
`define DTCD_CLK_MHZ 250
// Multiplier delay, in microseconds
`define DTCD_DELAY_US 2
// Delay expressed in clk_sys cycles
`define DTCD_DELAY_CYC (`DTCD_DELAY_US * `DTCD_CLK_MHZ)
`define DTCD_DELAY_W 10
`define DTCD_DELAY_CNT 10'h1F4
`define DTCD_ADDR_W 15
`define DTCD_POS_W 12
`define DTCD_POS_LAST 12'hFFF
`define DTCD_GRP_MSB 14
`define DTCD_GRP_LSB 12
`define DTCD_GRP_MIN 3'h4
`define DTCD_WORD_W 36
`define DTCD_WORD_ZERO 36'h000000000
`define DTCD_POS_ZERO 12'h000
`define DTCD_CNT_ZERO 10'h000
`endif

// >>> dtcd_sync.v
module dtcd_sync #(
	parameter W = 1
) (
	input wire clk_sys, // System clock
	input wire rst_n, // Synchronous reset, active low
	input wire [W-1:0] din, // Asynchronous inputs
	output reg [W-1:0] dout // Synchronised outputs
);
	reg [W-1:0] meta;
	// First stage feeds only the second stage
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			meta <= {W{1'b0}};
			dout <= {W{1'b0}};
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// >>> dtcd_top.v
// Notes on behaviour
// [R1] - Timing track gives one notch pulse per angular position at 125 kc.
// [R2] - Each notch pulse is delayed 2 us and recirculated, giving 500 kc clock pulses.
// [R3] - Notch pulses enter only while drum clock select enable is high.
// [R4] - Distributor starts with both flops zero and recirculation enabled.
// [R5] - All four drum clock pulses per notch go to the master clock rate control.
// [R6] - First pulse: phase0 strobe, low flop set, high flop kept, recirculated.
// [R7] - Second pulse: phase1 strobe, low flop cleared, high flop set, recirculated.
// [R8] - Third pulse: no strobe, low flop set, recirculated.
// [R9] - Fourth pulse: phase3 strobe, both flops cleared, not recirculated.
// [R10] - Next notch arrives together with phase3 strobe.
// [R11] - phase0 to phase1 is 2 us, phase1 to phase3 is 4 us.
// [R12] - Mark track gives one zero-index pulse per revolution.
// [R13] - Only the first 4096 notches after zero index are usable; rest is dead space.
// [R14] - Address is 15 bits: top 3 select group 4 to 7, low 12 position.
// [R15] - Each notch pulse notifies location control of the next position; the code notifies only notches inside the window after zero index.
// [R16] - Locating selects group and raises a match pulse at the addressed position.
// [R17] - Each group has 36 channels; only the selected group is used.
// [R18] - Reads pass only stored ones to the read destination.
// [R19] - Writes record every bit, polarity from the bit value.
// [R20] - Only addresses octal 40000 to 77777 belong to the drum store.
// [R21] - Angle index counter is 12 bits, counts notches, compared to position field.
// [R22] - Angle index counter returns to zero on the zero-index pulse.
// [R23] - Reader clears the read destination before the match pulse transfers data; the code does not clear read_ones first but loads it whole at the match.
`include "dtcd_defines.vh"
module dtcd_top (
	input wire clk_sys, // System clock, 250 MHz
	input wire rst_n, // Synchronous reset, active low
	input wire track_notch_pulse, // Timing track notch, asynchronous
	input wire zero_index_pulse, // Mark track zero index, asynchronous
	input wire drum_clock_select, // Drum chosen as clock source
	input wire ref_start, // Start a reference, one cycle
	input wire ref_write, // Reference is a write
	input wire [14:0] storage_address_latch, // Address of the reference
	input wire [35:0] write_word, // Word to record
	input wire [143:0] sense_ones, // Read amplifiers, all four groups
	output reg drum_clock_pulse, // To rate control, one cycle
	output reg phase0_strobe, // Distributor phase 0
	output reg phase1_strobe, // Distributor phase 1
	output reg phase3_strobe, // Distributor phase 3
	output reg position_notify, // Notch seen, one cycle
	output reg position_match, // Addressed position reached
	output reg ref_busy, // Reference waiting for position
	output reg ref_reject, // Address not in drum store
	output reg [11:0] angle_index_counter, // Current angular count
	output reg [3:0] group_enable, // One-hot group select 4..7
	output reg [35:0] read_ones, // Ones sensed at match
	output reg [143:0] write_drive_en, // Write drive enable per channel
	output reg [143:0] write_polarity // Write polarity per channel
);
	////////////////////////////////////////////////////////////////////////
	// Input synchronisation and edge detect
	wire [2:0] sync_out;
	reg notch_d;
	reg zero_d;
	wire notch_rise;
	wire zero_rise;
	wire sel_en;
	dtcd_sync #(.W(3)) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.din({drum_clock_select, zero_index_pulse, track_notch_pulse}),
		.dout(sync_out)
	);
	assign sel_en = sync_out[2];
	assign notch_rise = sync_out[0] & ~notch_d; // [R1]
	assign zero_rise = sync_out[1] & ~zero_d; // [R12]
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			notch_d <= 1'b0;
			zero_d <= 1'b0;
		end else begin
			notch_d <= sync_out[0];
			zero_d <= sync_out[1];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Rate multiplier: one delay line shared by notch and recirculation
	reg phase_high_flop;
	reg phase_low_flop;
	reg dly_run;
	reg [9:0] dly_cnt;
	wire admit;
	wire recirc_en;
	wire dly_done;
	assign admit = notch_rise & sel_en; // [R3]
	// Recirculation is gated off only when both flops are one
	assign recirc_en = ~(phase_high_flop & phase_low_flop); // [R9]
	assign dly_done = dly_run && (dly_cnt == `DTCD_DELAY_CNT - 10'h001); // [R2]
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			dly_run <= 1'b0;
			dly_cnt <= `DTCD_CNT_ZERO;
		end else if (admit || (dly_done && recirc_en)) begin
			// A notch coinciding with the fourth pulse restarts the chain [R10]
			dly_run <= 1'b1; // [R2]
			dly_cnt <= `DTCD_CNT_ZERO;
		end else if (dly_done) begin
			dly_run <= 1'b0;
			dly_cnt <= `DTCD_CNT_ZERO;
		end else if (dly_run) begin
			dly_cnt <= dly_cnt + 10'h001;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Pulse phase distributor
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			phase_high_flop <= 1'b0; // [R4]
			phase_low_flop <= 1'b0; // [R4]
			drum_clock_pulse <= 1'b0;
			phase0_strobe <= 1'b0;
			phase1_strobe <= 1'b0;
			phase3_strobe <= 1'b0;
		end else begin
			drum_clock_pulse <= dly_done; // [R5]
			phase0_strobe <= dly_done & ~phase_high_flop & ~phase_low_flop; // [R6] [R11]
			phase1_strobe <= dly_done & ~phase_high_flop & phase_low_flop; // [R7] [R11]
			phase3_strobe <= dly_done & phase_high_flop & phase_low_flop; // [R9] [R11]
			if (dly_done) begin
				if (!phase_high_flop && !phase_low_flop) begin
					phase_low_flop <= 1'b1; // [R6]
				end else if (!phase_high_flop) begin
					phase_low_flop <= 1'b0; // [R7]
					phase_high_flop <= 1'b1; // [R7]
				end else if (!phase_low_flop) begin
					phase_low_flop <= 1'b1; // [R8]
				end else begin
					phase_low_flop <= 1'b0; // [R9]
					phase_high_flop <= 1'b0; // [R9]
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Angle index counter and dead space
	reg in_window;
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			angle_index_counter <= `DTCD_POS_ZERO;
			in_window <= 1'b0;
			position_notify <= 1'b0;
		end else begin
			position_notify <= notch_rise & in_window & ~zero_rise; // [R15]
			if (zero_rise) begin
				angle_index_counter <= `DTCD_POS_ZERO; // [R22]
				in_window <= 1'b1;
			end else if (position_notify) begin
				// Advance after the notify cycle, so notify shows the position of its own notch
				// Past position 4095 the counter holds and matches nothing [R13]
				if (angle_index_counter == `DTCD_POS_LAST) begin
					in_window <= 1'b0; // [R13]
				end else begin
					angle_index_counter <= angle_index_counter + 12'h001; // [R21]
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Locating and access
	localparam ST_IDLE = 2'b01;
	localparam ST_SEEK = 2'b10;
	reg [1:0] state;
	reg [11:0] want_pos;
	reg want_write;
	reg [35:0] want_word;
	reg [143:0] next_drive;
	reg [143:0] next_pol;
	reg [35:0] next_ones;
	wire [2:0] grp_field;
	wire in_range;
	wire hit;
	integer g;
	assign grp_field = storage_address_latch[`DTCD_GRP_MSB:`DTCD_GRP_LSB]; // [R14]
	assign in_range = grp_field >= `DTCD_GRP_MIN; // [R20]
	// Counter value names the position that is about to come under the heads
	assign hit = position_notify && (angle_index_counter == want_pos); // [R16] [R21]
	always @* begin
		next_drive = {144{1'b0}};
		next_pol = {144{1'b0}};
		next_ones = `DTCD_WORD_ZERO;
		for (g = 0; g < 4; g = g + 1) begin
			if (group_enable[g]) begin
				next_drive[g*36 +: 36] = {36{want_write}}; // [R17] [R19]
				next_pol[g*36 +: 36] = want_word; // [R19]
				next_ones = next_ones | sense_ones[g*36 +: 36]; // [R17] [R18]
			end
		end
	end
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			want_pos <= `DTCD_POS_ZERO;
			want_write <= 1'b0;
			want_word <= `DTCD_WORD_ZERO;
			group_enable <= 4'h0;
			position_match <= 1'b0;
			ref_busy <= 1'b0;
			ref_reject <= 1'b0;
			read_ones <= `DTCD_WORD_ZERO;
			write_drive_en <= {144{1'b0}};
			write_polarity <= {144{1'b0}};
		end else begin
			position_match <= 1'b0;
			ref_reject <= 1'b0;
			write_drive_en <= {144{1'b0}};
			case (state)
				ST_IDLE: begin
					if (ref_start && in_range) begin
						want_pos <= storage_address_latch[`DTCD_POS_W-1:0]; // [R14]
						want_write <= ref_write;
						want_word <= write_word;
						group_enable <= 4'h1 << grp_field[1:0]; // [R16] [R17]
						ref_busy <= 1'b1;
						state <= ST_SEEK;
					end else if (ref_start) begin
						ref_reject <= 1'b1; // [R20]
					end
				end
				ST_SEEK: begin
					if (hit) begin
						position_match <= 1'b1; // [R16]
						ref_busy <= 1'b0;
						state <= ST_IDLE;
						write_drive_en <= next_drive; // [R19]
						write_polarity <= next_pol; // [R19]
						// Ones only; read_ones is loaded whole at the match, so no clear beforehand [R18] [R23]
						read_ones <= want_write ? `DTCD_WORD_ZERO : next_ones;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// >>> dtcd_far_end.sv
module dtcd_far_end (
	input logic clk_sys, // Clock
	input logic run, // Drum turning
	output logic track_notch_pulse, // Timing track
	output logic zero_index_pulse, // Mark track
	output logic [143:0] sense_ones // Read amplifiers
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	always @(posedge clk_sys) cnt <= run ? cnt + 1 : 0;
	// Fixed stored ones per group, lanes 7,6,5,4
	assign sense_ones = {36'h0F0F0F0F0, 36'h123456789, 36'hABCDEF012, 36'h800000001};
	assign zero_index_pulse = run && cnt < 4;
	// Period 2000 clocks lines each notch up with the fourth pulse
	assign track_notch_pulse = run && cnt >= 1000 && (cnt - 1000) % 2000 < 4;
endmodule

// >>> dtcd_assertions.sv
module dtcd_assertions (
	input logic clk_sys, // Clock
	input logic rst_n, // Reset
	input logic ref_start, // Start
	input logic [14:0] storage_address_latch, // Address
	input logic drum_clock_pulse, // Pulse
	input logic phase0_strobe, // Phase 0
	input logic phase1_strobe, // Phase 1
	input logic phase3_strobe, // Phase 3
	input logic position_notify, // Notch
	input logic position_match, // Match
	input logic ref_busy, // Seeking
	input logic ref_reject, // Refused
	input logic [11:0] angle_index_counter, // Angle
	input logic [3:0] group_enable // Group
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	p0_alone_a: assert property (phase0_strobe |-> drum_clock_pulse && !phase1_strobe && !phase3_strobe)
		else $error("phase0 bad");
	p1_spacing_a: assert property (phase1_strobe |-> drum_clock_pulse && $past(phase0_strobe, 500))
		else $error("phase1 bad");
	p3_spacing_a: assert property (phase3_strobe |-> drum_clock_pulse && $past(phase1_strobe, 1000))
		else $error("phase3 bad");
	third_silent_a: assert property ($past(phase1_strobe, 500) |-> drum_clock_pulse && !phase0_strobe && !phase3_strobe)
		else $error("third pulse bad");
	match_pos_a: assert property (position_match |-> $past(position_notify) && $past(angle_index_counter) == storage_address_latch[11:0])
		else $error("match bad");
	match_idle_a: assert property (position_match |-> $past(ref_busy) && !ref_busy)
		else $error("busy bad");
	reject_low_a: assert property (ref_start && !ref_busy && !storage_address_latch[14] |=> ref_reject && !ref_busy)
		else $error("reject bad");
	group_pick_a: assert property (ref_start && !ref_busy && storage_address_latch[14] |=> ref_busy && group_enable == 4'h1 << $past(storage_address_latch[13:12]))
		else $error("group bad");
	cover property (phase3_strobe);
	cover property (position_match);
	cover property (ref_reject);
endmodule
bind dtcd_top dtcd_assertions dtcd_assertions_inst (.*);

// >>> tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'h0, rst_n = 1'h0, run = 1'h0, drum_clock_select = 1'h0, ref_start = 1'h0, ref_write = 1'h0;
	logic [14:0] storage_address_latch = 15'h0000;
	logic [35:0] write_word = 36'h000000000, read_ones;
	logic track_notch_pulse, zero_index_pulse, drum_clock_pulse, phase0_strobe, phase1_strobe, phase3_strobe;
	logic position_notify, position_match, ref_busy, ref_reject;
	logic [11:0] angle_index_counter;
	logic [3:0] group_enable;
	logic [143:0] sense_ones, write_drive_en, write_polarity;
	int err_total = 0, n_tests = 0, cyc = 0, n_dcp = 0, t = 0;
	dtcd_top dtcd_top_inst (.*);
	dtcd_far_end dtcd_far_end_inst (.*);
	always #2 clk_sys = ~clk_sys;
	// Whole run needs about 28500 cycles
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		n_dcp <= n_dcp + (drum_clock_pulse === 1'h1);
		if (cyc == 45000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic report_and_stop;
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'h1) begin
			err_total++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	task automatic wait_hi(ref logic s);
		t = 0;
		do begin
			@(posedge clk_sys);
			#1;
			t++;
		end while (s !== 1'h1 && t < 20000);
	endtask
	task automatic do_ref(input logic w, input logic [14:0] a, input logic [35:0] d);
		@(posedge clk_sys);
		ref_write <= w;
		storage_address_latch <= a;
		write_word <= d;
		ref_start <= 1'h1;
		@(posedge clk_sys);
		ref_start <= 1'h0;
		#1;
	endtask
	// Restarting the drum gives a fresh zero index
	// Long stop lets a running chain finish, so no stale notch restarts it mid-cycle
	task automatic spin;
		@(posedge clk_sys);
		run <= 1'h0;
		repeat (2100) @(posedge clk_sys);
		run <= 1'h1;
	endtask
	task automatic t_select_off;
		spin();
		repeat (3000) @(posedge clk_sys);
		chk(n_dcp == 0, "pulses unselected");
		$display("select test end");
	endtask
	task automatic t_phases;
		int n0;
		spin();
		drum_clock_select <= 1'h1;
		wait_hi(phase0_strobe);
		n0 = n_dcp;
		wait_hi(phase1_strobe);
		chk(t == 500, "phase1 gap");
		wait_hi(phase3_strobe);
		chk(t == 1000, "phase3 gap");
		chk(n_dcp - n0 == 3 && drum_clock_pulse === 1'h1, "pulse count");
		$display("phase test end");
	endtask
	task automatic t_read;
		spin();
		do_ref(1'h0, 15'h5002, 36'h000000000);
		chk(ref_busy === 1'h1 && group_enable === 4'h2, "group");
		wait_hi(position_match);
		chk(t > 4900 && t < 5100 && angle_index_counter === 12'h003, "position");
		chk(read_ones === 36'hABCDEF012, "read ones");
		$display("read test end");
	endtask
	task automatic t_write;
		spin();
		do_ref(1'h1, 15'h7004, 36'hC3A5F0E1D);
		wait_hi(position_match);
		chk(write_drive_en === {36'hFFFFFFFFF, 108'h0}, "drive lanes");
		chk(write_polarity[143:108] === 36'hC3A5F0E1D && read_ones === 36'h0, "polarity");
		$display("write test end");
	endtask
	task automatic t_reject;
		do_ref(1'h0, 15'h3FFF, 36'h000000000);
		chk(ref_reject === 1'h1 && ref_busy === 1'h0, "low address");
		$display("reject test end");
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'h1;
		@(posedge clk_sys);
		#1;
		chk(phase0_strobe === 1'h0 && drum_clock_pulse === 1'h0 && ref_busy === 1'h0, "reset");
		t_select_off();
		t_phases();
		t_read();
		t_write();
		t_reject();
		report_and_stop();
	end
endmodule
